// ### pkg/timer_pkg.sv
// constants and types shared by the buffered, cascaded pwm timer
package timer_pkg;
  // bus and array sizes
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int NUM_CH = 3;
  localparam int NUM_GR = 8;
  // register offsets, channel blocks hold ctrl, mode, io, counter, then general regs
  localparam logic [4:0] ADDR_START = 5'h00;
  localparam logic [4:0] CH0_BASE = 5'h01;
  localparam logic [4:0] CH1_BASE = 5'h09;
  localparam logic [4:0] CH2_BASE = 5'h0F;
  localparam logic [4:0] ADDR_PIN_STATUS = 5'h15;
  localparam logic [4:0] CH0_SPAN = 5'h08;
  localparam logic [4:0] CH12_SPAN = 5'h06;
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_MODE = 3'h1;
  localparam logic [2:0] OFS_IO = 3'h2;
  localparam logic [2:0] OFS_CNT = 3'h3;
  localparam logic [2:0] OFS_GR = 3'h4;
  // channel_control_reg fields
  localparam int PSC_LSB = 0;
  localparam int CLR_LSB = 3;
  localparam logic [2:0] PSC_DIV1 = 3'h0;
  localparam logic [2:0] PSC_DIV4 = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam logic [2:0] PSC_DIV64 = 3'h3;
  localparam logic [2:0] PSC_CASCADE = 3'h7;
  localparam logic [2:0] CLR_GR_A = 3'h1;
  localparam logic [2:0] CLR_GR_B = 3'h2;
  localparam logic [2:0] CLR_GR_C = 3'h3;
  localparam logic [2:0] CLR_GR_D = 3'h4;
  // channel_mode_reg fields
  localparam int BFA_BIT = 4;
  localparam int BFB_BIT = 5;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PWM1 = 4'h2;
  localparam logic [3:0] MODE_PWM2 = 4'h3;
  localparam logic [3:0] MODE_PHASE = 4'h4;
  // io_control_reg field, one nibble per general register
  localparam int IO_FIELD_W = 4;
  localparam int IO_INIT_BIT = 2;
  localparam int IO_CAPT_BIT = 3;
  typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} pin_act_t;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] IO_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [2:0] START_RST = 3'h0;
  // prescaler divider
  localparam int DIV_W = 6;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;
endpackage

// ### core/timer_counter16.sv
// one channel_counter with load, clear and up/down steps
`timescale 1ns/1ns
module timer_counter16 #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic inc,
  input wire logic dec,
  input wire logic clr,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic [WIDTH-1:0] count_r,
  output logic ovf,
  output logic udf
);
  import timer_pkg::*;

  // wrap events, suppressed when a load or clear takes the cycle
  assign ovf = inc && (&count_r) && !clr && !load;
  assign udf = dec && (count_r == '0) && !clr && !load;

  // load beats clear beats count
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_r <= CNT_RST;
    end else if (load) begin
      count_r <= load_val;
    end else if (clr) begin
      count_r <= '0;
    end else if (inc) begin
      count_r <= count_r + 1'b1;
    end else if (dec) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule

// ### core/compare_pin.sv
// output level flip-flop of one compare pin
`timescale 1ns/1ns
module compare_pin (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic restore,
  input wire logic init_level,
  input wire timer_pkg::pin_act_t act,
  output logic level_r
);
  import timer_pkg::*;

  // restore loads the initial level, otherwise apply the match action
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      level_r <= 1'b0;
    end else if (restore) begin
      level_r <= init_level;
    end else begin
      case (act)
        ACT_LOW: level_r <= 1'b0;
        ACT_HIGH: level_r <= 1'b1;
        ACT_TOGGLE: level_r <= ~level_r;
        default: level_r <= level_r;
      endcase
    end
  end
endmodule

// ### core/timer_buffer_cascade_pwm.sv
// three-channel timer with buffer transfers, 32-bit cascade and two pwm modes
`timescale 1ns/1ns
module timer_buffer_cascade_pwm (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [timer_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [timer_pkg::NUM_GR-1:0] capture_evt,
  input wire logic [1:0] phase_inc,
  input wire logic [1:0] phase_dec,
  output logic ch0_pin_a,
  output logic ch0_pin_b,
  output logic ch0_pin_c,
  output logic ch0_pin_d,
  output logic ch1_pin_a,
  output logic ch1_pin_b,
  output logic ch2_pin_a,
  output logic ch2_pin_b
);
  import timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and wiring
  logic [2:0] start_r;
  logic [DATA_W-1:0] ctrl_r [NUM_CH];
  logic [DATA_W-1:0] mode_r [NUM_CH];
  logic [DATA_W-1:0] io_r [NUM_CH];
  logic [DATA_W-1:0] gr_r [NUM_GR];
  logic [DATA_W-1:0] cnt [NUM_CH];
  logic [DIV_W-1:0] div_r;
  logic inc [NUM_CH];
  logic dec [NUM_CH];
  logic clr [NUM_CH];
  logic load [NUM_CH];
  logic ovf [NUM_CH];
  logic udf [NUM_CH];
  logic [NUM_GR-1:0] match;
  logic [NUM_GR-1:0] cap;
  logic [NUM_GR-1:0] level;
  logic [NUM_GR-1:0] restore;
  logic [NUM_GR-1:0] init_lvl;
  pin_act_t act [NUM_GR];
  logic sel_ok;
  logic [1:0] sel_ch;
  logic [2:0] sel_ofs;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // channel that owns general register i
  function automatic int chan_of(input int i);
    if (i < 4) begin
      return 0;
    end else if (i < 6) begin
      return 1;
    end
    return 2;
  endfunction

  // index of a channel's first general register
  function automatic int base_of(input int c);
    if (c == 0) begin
      return 0;
    end else if (c == 1) begin
      return 4;
    end
    return 6;
  endfunction

  // io nibble of local register li
  function automatic logic [3:0] io_of(input logic [15:0] io, input int li);
    return io[li*IO_FIELD_W +: IO_FIELD_W];
  endfunction

  // prescaled count enable
  function automatic logic presc_tick(input logic [2:0] psc, input logic [5:0] div);
    logic t;
    t = 1'b0;
    case (psc)
      PSC_DIV1: t = 1'b1;
      PSC_DIV4: t = (div & DIV4_MASK) == 6'h00;
      PSC_DIV16: t = (div & DIV16_MASK) == 6'h00;
      PSC_DIV64: t = (div & DIV64_MASK) == 6'h00;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // general register chosen as clear source, -1 when none
  function automatic int clr_reg(input int c, input logic [2:0] code);
    int r;
    r = -1;
    if (code == CLR_GR_A) begin
      r = base_of(c);
    end else if (code == CLR_GR_B) begin
      r = base_of(c) + 1;
    end else if (code == CLR_GR_C && c == 0) begin
      r = 2;
    end else if (code == CLR_GR_D && c == 0) begin
      r = 3;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    sel_ok = 1'b0;
    sel_ch = 2'd0;
    sel_ofs = 3'd0;
    if (reg_addr >= CH2_BASE && reg_addr < CH2_BASE + CH12_SPAN) begin
      sel_ok = 1'b1;
      sel_ch = 2'd2;
      sel_ofs = 3'(reg_addr - CH2_BASE);
    end else if (reg_addr >= CH1_BASE && reg_addr < CH1_BASE + CH12_SPAN) begin
      sel_ok = 1'b1;
      sel_ch = 2'd1;
      sel_ofs = 3'(reg_addr - CH1_BASE);
    end else if (reg_addr >= CH0_BASE && reg_addr < CH0_BASE + CH0_SPAN) begin
      sel_ok = 1'b1;
      sel_ch = 2'd0;
      sel_ofs = 3'(reg_addr - CH0_BASE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // counter_start_reg, one counter_run_bit per channel
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      start_r <= START_RST;
    end else if (reg_wr && reg_addr == ADDR_START) begin
      start_r <= reg_wdata[2:0];
    end
  end

  // control, mode and io control per channel
  // buffer enables
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_r[c] <= CTRL_RST;
        mode_r[c] <= MODE_RST;
        io_r[c] <= IO_RST;
      end
    end else if (reg_wr && sel_ok) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (int'(sel_ch) == c) begin
          if (sel_ofs == OFS_CTRL) begin
            ctrl_r[c] <= reg_wdata;
          end else if (sel_ofs == OFS_MODE) begin
            mode_r[c] <= reg_wdata;
          end else if (sel_ofs == OFS_IO) begin
            io_r[c] <= reg_wdata;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and count steps

  // free divider feeding prescale enables
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // channel 0 and 2 count sources
  always_comb begin
    inc[0] = start_r[0] && presc_tick(ctrl_r[0][PSC_LSB +: 3], div_r);
    dec[0] = 1'b0;
    if (mode_r[2][3:0] == MODE_PHASE) begin
      inc[2] = start_r[2] && phase_inc[1];
      dec[2] = start_r[2] && phase_dec[1];
    end else begin
      inc[2] = start_r[2] && presc_tick(ctrl_r[2][PSC_LSB +: 3], div_r);
      dec[2] = 1'b0;
    end
  end

  // channel 1 count source, cascaded from channel 2 wraps
  always_comb begin
    if (mode_r[1][3:0] == MODE_PHASE) begin
      inc[1] = start_r[1] && phase_inc[0];
      dec[1] = start_r[1] && phase_dec[0];
    end else if (ctrl_r[1][PSC_LSB +: 3] == PSC_CASCADE) begin
      // up on overflow, down on underflow, same cycle
      inc[1] = start_r[1] && ovf[2];
      dec[1] = start_r[1] && udf[2];
    end else begin
      inc[1] = start_r[1] && presc_tick(ctrl_r[1][PSC_LSB +: 3], div_r);
      dec[1] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare match, capture and counter clear

  // match on each counter step, capture from gated input events
  always_comb begin
    for (int i = 0; i < NUM_GR; i++) begin
      logic [3:0] f;
      int c;
      c = chan_of(i);
      f = io_of(io_r[c], i - base_of(c));
      match[i] = !f[IO_CAPT_BIT] && (inc[c] || dec[c]) && cnt[c] == gr_r[i];
      cap[i] = f[IO_CAPT_BIT] && start_r[c] && capture_evt[i];
    end
  end

  // selected register event clears the counter
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      int r;
      r = clr_reg(c, ctrl_r[c][CLR_LSB +: 3]);
      clr[c] = (r >= 0) && (match[r < 0 ? 0 : r] || cap[r < 0 ? 0 : r]);
      load[c] = reg_wr && sel_ok && int'(sel_ch) == c && sel_ofs == OFS_CNT;
    end
  end

  // three counters, 1 and 2 chain into 32 bits
  for (genvar g = 0; g < NUM_CH; g++) begin : g_cnt
    timer_counter16 #(.WIDTH(DATA_W)) u_cnt (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .inc(inc[g]),
      .dec(dec[g]),
      .clr(clr[g]),
      .load(load[g]),
      .load_val(reg_wdata),
      .count_r(cnt[g]),
      .ovf(ovf[g]),
      .udf(udf[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // general registers

  // software writes first, hardware transfers after so they win
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_GR; i++) begin
        gr_r[i] <= GR_RST;
      end
    end else begin
      for (int i = 0; i < NUM_GR; i++) begin
        if (reg_wr && sel_ok && sel_ofs >= OFS_GR
            && base_of(int'(sel_ch)) + int'(sel_ofs - OFS_GR) == i) begin
          gr_r[i] <= reg_wdata;
        end
        if (cap[i]) begin
          gr_r[i] <= cnt[chan_of(i)];
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (mode_r[0][BFA_BIT + k]) begin
          if (cap[k]) begin
            // capture shifts old value to buffer
            gr_r[k] <= cnt[0];
            gr_r[k + 2] <= gr_r[k];
          end else if (match[k]) begin
            gr_r[k] <= gr_r[k + 2];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin actions

  // per pin action from mode, match and clear
  always_comb begin
    for (int p = 0; p < NUM_GR; p++) begin
      logic [3:0] f;
      logic [3:0] fq;
      logic [3:0] m;
      int c;
      int li;
      int q;
      int pr;
      int pi;
      c = chan_of(p);
      li = p - base_of(c);
      q = (p < NUM_GR - 1) ? p + 1 : p;
      f = io_of(io_r[c], li);
      fq = io_of(io_r[c], (li < 3) ? li + 1 : li);
      m = mode_r[c][3:0];
      pr = clr_reg(c, ctrl_r[c][CLR_LSB +: 3]);
      pi = (pr < 0) ? 0 : pr;
      init_lvl[p] = f[IO_INIT_BIT];
      restore[p] = !start_r[c];
      act[p] = ACT_NONE;
      if (m == MODE_PWM1) begin
        // only A and C pins carry the pair
        if (li % 2 == 0) begin
          if (gr_r[p] != gr_r[q]) begin
            if (match[p]) begin
              act[p] = pin_act_t'(f[1:0]);
            end else if (match[q]) begin
              act[p] = pin_act_t'(fq[1:0]);
            end
          end
        end
      end else if (m == MODE_PWM2) begin
        if (pr == p) begin
          act[p] = ACT_NONE;
        end else if (clr[c]) begin
          restore[p] = 1'b1;
        end else if (match[p] && !(pr >= 0 && gr_r[p] == gr_r[pi])) begin
          act[p] = pin_act_t'(f[1:0]);
        end
      end else if (match[p]) begin
        act[p] = pin_act_t'(f[1:0]);
      end
    end
  end

  // pin level flip-flops
  for (genvar g = 0; g < NUM_GR; g++) begin : g_pin
    compare_pin u_pin (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restore(restore[g]),
      .init_level(init_lvl[g]),
      .act(act[g]),
      .level_r(level[g])
    );
  end

  assign ch0_pin_a = level[0];
  assign ch0_pin_b = level[1];
  assign ch0_pin_c = level[2];
  assign ch0_pin_d = level[3];
  assign ch1_pin_a = level[4];
  assign ch1_pin_b = level[5];
  assign ch2_pin_a = level[6];
  assign ch2_pin_b = level[7];

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == ADDR_START) begin
      reg_rdata <= {13'h0000, start_r};
    end else if (reg_addr == ADDR_PIN_STATUS) begin
      reg_rdata <= {8'h00, level};
    end else if (sel_ok && sel_ofs == OFS_CTRL) begin
      reg_rdata <= ctrl_r[sel_ch];
    end else if (sel_ok && sel_ofs == OFS_MODE) begin
      reg_rdata <= mode_r[sel_ch];
    end else if (sel_ok && sel_ofs == OFS_IO) begin
      reg_rdata <= io_r[sel_ch];
    end else if (sel_ok && sel_ofs == OFS_CNT) begin
      reg_rdata <= cnt[sel_ch];
    end else if (sel_ok) begin
      reg_rdata <= gr_r[base_of(int'(sel_ch)) + int'(sel_ofs - OFS_GR)];
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// ### tb/timer_buffer_cascade_pwm_sva.sv
// port checker for the buffered cascade pwm timer
`timescale 1ns/1ns
module timer_buffer_cascade_pwm_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [timer_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ch0_pin_a,
  input wire logic ch0_pin_b,
  input wire logic ch0_pin_c,
  input wire logic ch0_pin_d,
  input wire logic ch1_pin_a,
  input wire logic ch1_pin_b,
  input wire logic ch2_pin_a,
  input wire logic ch2_pin_b
);
  import timer_pkg::*;
  logic [2:0] run_sh_r;
  logic [7:0] pins_w;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // pin levels in capture order
  assign pins_w = {ch2_pin_b, ch2_pin_a, ch1_pin_b, ch1_pin_a,
                   ch0_pin_d, ch0_pin_c, ch0_pin_b, ch0_pin_a};
  // shadow of the run bits as software wrote them
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      run_sh_r <= 3'h0;
    end else if (reg_wr && reg_addr == ADDR_START) begin
      run_sh_r <= reg_wdata[2:0];
    end
  end
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero after idle cycle");
  property p_unmapped;
    reg_rd && reg_addr > ADDR_PIN_STATUS |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read gave nonzero data");
  property p_start_rb;
    reg_rd && reg_addr == ADDR_START |=> reg_rdata == {13'h0000, $past(run_sh_r)};
  endproperty
  a_start_rb: assert property (p_start_rb)
    else $error("start register readback wrong");
  property p_pin_status;
    reg_rd && reg_addr == ADDR_PIN_STATUS |=> reg_rdata == {8'h00, $past(pins_w)};
  endproperty
  a_pin_status: assert property (p_pin_status)
    else $error("pin status read differs from pins");
  property p_reset_pins;
    $rose(reset_n) |-> pins_w == 8'h00;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pins not low after reset");
  property p_ch0_hold;
    (!run_sh_r[0] && !reg_wr) [*2] |=> $stable(pins_w[3:0]);
  endproperty
  a_ch0_hold: assert property (p_ch0_hold)
    else $error("channel 0 pin moved while stopped");
  property p_ch1_hold;
    !run_sh_r[1] && !reg_wr && !$past(reg_wr) |=> $stable({ch1_pin_a, ch1_pin_b});
  endproperty
  a_ch1_hold: assert property (p_ch1_hold)
    else $error("channel 1 pin moved while stopped");
  property p_ch2_hold;
    !run_sh_r[2] && !$past(run_sh_r[2]) && !reg_wr && !$past(reg_wr) |=> $stable(pins_w[7:6]);
  endproperty
  a_ch2_hold: assert property (p_ch2_hold)
    else $error("channel 2 pin moved while stopped");
endmodule
bind timer_buffer_cascade_pwm timer_buffer_cascade_pwm_chk chk_u (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ch0_pin_a(ch0_pin_a), .ch0_pin_b(ch0_pin_b), .ch0_pin_c(ch0_pin_c),
  .ch0_pin_d(ch0_pin_d), .ch1_pin_a(ch1_pin_a), .ch1_pin_b(ch1_pin_b),
  .ch2_pin_a(ch2_pin_a), .ch2_pin_b(ch2_pin_b)
);

// ### tb/pin_watch.sv
// waveform consumer model counting level changes on each compare pin
`timescale 1ns/1ns
module pin_watch (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] pins,
  output int edges [8]
);
  logic [7:0] last_r;
  // count a change whenever a pin differs from its previous level
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      last_r <= 8'h00;
    end else begin
      last_r <= pins;
      for (int i = 0; i < 8; i++) begin
        if (pins[i] !== last_r[i]) edges[i] <= edges[i] + 1;
      end
    end
  end
endmodule

// ### tb/timer_buffer_cascade_pwm_test.sv
// self-checking bench for the buffered cascade pwm timer
`timescale 1ns/1ns
module timer_buffer_cascade_pwm_test;
  typedef struct packed {logic wr; logic [4:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic core_clk = 1'b0;
  logic reset_n, reg_wr, reg_rd;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0] capture_evt;
  // each bit is driven by its own pin port, so this is a net
  wire [7:0] pins;
  logic [1:0] phase_inc, phase_dec;
  int edges [8];
  int num_errors = 0;
  int samples_checked = 0;
  row_t rows [10] = '{'{1'b0, 5'h06, 16'h0000, 16'hFFFF}, '{1'b0, 5'h0D, 16'h0000, 16'hFFFF},
    '{1'b0, 5'h01, 16'h0000, 16'h0000}, '{1'b0, 5'h15, 16'h0000, 16'h0000},
    '{1'b1, 5'h13, 16'h1234, 16'h1234}, '{1'b1, 5'h09, 16'h000F, 16'h000F},
    '{1'b1, 5'h02, 16'h0030, 16'h0030}, '{1'b1, 5'h16, 16'hABCD, 16'h0000},
    '{1'b1, 5'h00, 16'h0005, 16'h0005}, '{1'b1, 5'h00, 16'h0000, 16'h0000}};
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  timer_buffer_cascade_pwm dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_evt(capture_evt),
    .phase_inc(phase_inc), .phase_dec(phase_dec),
    .ch0_pin_a(pins[0]), .ch0_pin_b(pins[1]), .ch0_pin_c(pins[2]), .ch0_pin_d(pins[3]),
    .ch1_pin_a(pins[4]), .ch1_pin_b(pins[5]), .ch2_pin_a(pins[6]), .ch2_pin_b(pins[7])
  );
  pin_watch pw_u (.core_clk(core_clk), .reset_n(reset_n), .pins(pins), .edges(edges));
  ////////////////////////////////////////////////////////////////////////////////
  // bus and stimulus tasks
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input string n, input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic pulse(input logic [7:0] cap, input logic [1:0] up, input logic [1:0] dn);
    @(posedge core_clk);
    capture_evt <= cap;
    phase_inc <= up;
    phase_dec <= dn;
    @(posedge core_clk);
    capture_evt <= 8'h00;
    phase_inc <= 2'b00;
    phase_dec <= 2'b00;
  endtask
  // count pin changes over a window after a settling gap
  task automatic edges_in(input int p, input int n, input int e, input string s);
    int c0;
    repeat (8) @(posedge core_clk);
    c0 = edges[p];
    repeat (n) @(posedge core_clk);
    chk(s, 16'(e), 16'(edges[p] - c0));
  endtask
  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    capture_evt = 8'h00;
    phase_inc = 2'b00;
    phase_dec = 2'b00;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rdchk($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
    end
    // periodic toggle, clear on match A at 3
    wr(5'h02, 16'h0000);
    wr(5'h01, 16'h0008);
    wr(5'h05, 16'h0003);
    wr(5'h03, 16'h0003);
    wr(5'h04, 16'h0000);
    wr(5'h00, 16'h0001);
    edges_in(0, 16, 4, "ch0 toggles");
    // divide by 4 and clear on match C, toggle every 16 cycles
    wr(5'h07, 16'h0003);
    wr(5'h01, 16'h0019);
    edges_in(0, 32, 2, "ch0 div4 clear c");
    // pwm 1 with buffered A: period 8, A reloaded from C
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h0010);
    wr(5'h06, 16'h0007);
    wr(5'h05, 16'h0002);
    wr(5'h07, 16'h0005);
    wr(5'h03, 16'h0012);
    wr(5'h04, 16'h0000);
    wr(5'h02, 16'h0012);
    wr(5'h00, 16'h0001);
    edges_in(0, 16, 4, "pwm1 pin a");
    wr(5'h00, 16'h0000);
    rdchk("ch0 a reloaded", 5'h05, 16'h0005);
    // buffered capture on B with a frozen counter
    wr(5'h02, 16'h0020);
    wr(5'h01, 16'h0004);
    wr(5'h03, 16'h0080);
    wr(5'h06, 16'h1111);
    wr(5'h04, 16'h0050);
    wr(5'h00, 16'h0001);
    pulse(8'h02, 2'b00, 2'b00);
    wr(5'h04, 16'h0060);
    pulse(8'h02, 2'b00, 2'b00);
    wr(5'h00, 16'h0000);
    rdchk("ch0 b capture", 5'h06, 16'h0060);
    rdchk("ch0 d buffer", 5'h08, 16'h0050);
    // cascade: ch2 phase steps wrap into ch1
    wr(5'h09, 16'h0007);
    wr(5'h0F, 16'h0000);
    wr(5'h10, 16'h0004);
    wr(5'h12, 16'hFFFE);
    wr(5'h0C, 16'h0010);
    wr(5'h00, 16'h0006);
    repeat (3) pulse(8'h00, 2'b10, 2'b00);
    rdchk("ch2 lower up", 5'h12, 16'h0001);
    rdchk("ch1 upper up", 5'h0C, 16'h0011);
    repeat (3) pulse(8'h00, 2'b00, 2'b10);
    rdchk("ch2 lower down", 5'h12, 16'hFFFE);
    rdchk("ch1 upper down", 5'h0C, 16'h0010);
    // phase mode on ch1 ignores cascade clocking
    wr(5'h0A, 16'h0004);
    repeat (3) pulse(8'h00, 2'b10, 2'b00);
    pulse(8'h00, 2'b01, 2'b00);
    rdchk("ch1 phase only", 5'h0C, 16'h0011);
    wr(5'h00, 16'h0000);
    // pwm 1 pair with equal values
    wr(5'h0A, 16'h0002);
    wr(5'h09, 16'h0008);
    wr(5'h0D, 16'h0004);
    wr(5'h0E, 16'h0004);
    wr(5'h0B, 16'h0013);
    wr(5'h0C, 16'h0000);
    wr(5'h00, 16'h0002);
    edges_in(4, 16, 0, "pwm1 equal pair");
    wr(5'h00, 16'h0000);
    // pwm 2 on ch2: A at 5 gives period 6, B at 2 gives 3 cycles high
    wr(5'h10, 16'h0003);
    wr(5'h0F, 16'h0008);
    wr(5'h13, 16'h0005);
    wr(5'h14, 16'h0002);
    wr(5'h11, 16'h0027);
    wr(5'h12, 16'h0000);
    wr(5'h00, 16'h0004);
    edges_in(7, 24, 8, "pwm2 duty pin");
    edges_in(6, 24, 0, "pwm2 period pin");
    wr(5'h14, 16'h0005);
    edges_in(7, 24, 0, "pwm2 duty equal");
    @(negedge core_clk);
    chk("pwm2 equal level", 16'h0000, {15'h0000, pins[7]});
    // reset in mid-run
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rdchk("ch2 a after reset", 5'h13, 16'hFFFF);
    chk("pins after reset", 16'h0000, {8'h00, pins});
    conclude();
  end
endmodule
